// ==== tb/adc_sequencer_control_bench.sv ====
/*
  adc_sequencer_control_bench: self-checking bench of the sequencer.
  Assumes one AHB-Lite slave and the front model on the convert side.
*/
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin testsRun++; if ((got) !== (ex)) begin \
  errors++; $display("CHECK FAILED %s expected %0h seen %0h", nm, ex, \
  got); end end
module adc_sequencer_control_bench import adsq_pkg::*;;
  typedef struct {logic [1:0] refc; logic [2:0] mode; logic [15:0] lo;
    logic [15:0] hi; logic hit;} adsq_row_t;
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic eventTrigger = 1'b0;
  logic deepSleepWake = 1'b0;
  logic cvPrev = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [15:0] windowLowThreshold = 16'h0;
  logic [15:0] windowHighThreshold = 16'h0;
  logic [9:0] level = 10'h064;
  logic [7:0] lat = 8'h00;
  logic hreadyout, hresp, resultValid, converterClock, sampleCapOpen;
  logic sampleTrack, convertRequest, irq;
  logic [31:0] hrdata;
  logic [9:0] sampleResult;
  logic [1:0] referenceSelect;
  logic [4:0] inputSelect;
  logic [15:0] conversionOutput;
  int errors = 0, testsRun = 0, capCycles = 0, trackCycles = 0;
  int validCount = 0;
  // window cases: reference, mode, thresholds, expected match; level 0x64
  adsq_row_t rows[9] = '{
    '{2'h0, 3'h0, 16'h0000, 16'hFFFF, 1'b0},
    '{2'h1, 3'h1, 16'h0065, 16'h0000, 1'b1},
    '{2'h2, 3'h1, 16'h0064, 16'h0000, 1'b0},
    '{2'h0, 3'h2, 16'h0000, 16'h0063, 1'b1},
    '{2'h1, 3'h2, 16'h0000, 16'h0064, 1'b0},
    '{2'h2, 3'h3, 16'h0063, 16'h0065, 1'b1},
    '{2'h0, 3'h3, 16'h0064, 16'h0065, 1'b0},
    '{2'h1, 3'h4, 16'h0064, 16'h0063, 1'b1},
    '{2'h2, 3'h5, 16'hFFFF, 16'h0000, 1'b0}};
  logic [5:0] regs[13] = '{IDX_CONTROL, IDX_ACCUM, IDX_CLOCK, IDX_TIMING,
    IDX_WINDOW, IDX_SAMPLE_LENGTH_EXTENSION, IDX_INPUT, IDX_COMMAND, IDX_EVENT, IDX_INTEN,
    IDX_STATUS, IDX_DEBUG, IDX_RESULT};

  adsq_sequencer uut (.sys_clk(sys_clk), .srst(srst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .eventTrigger(eventTrigger),
    .deepSleepWake(deepSleepWake), .windowLowThreshold(windowLowThreshold),
    .windowHighThreshold(windowHighThreshold), .resultValid(resultValid),
    .sampleResult(sampleResult), .referenceSelect(referenceSelect),
    .inputSelect(inputSelect), .converterClock(converterClock),
    .sampleCapOpen(sampleCapOpen), .sampleTrack(sampleTrack),
    .convertRequest(convertRequest), .conversionOutput(conversionOutput),
    .irq(irq));
  adsq_front_model front (.sys_clk(sys_clk), .srst(srst),
    .convertRequest(convertRequest), .level(level), .lat(lat),
    .resultValid(resultValid), .sampleResult(sampleResult));

  // clock and cut-off for a hang
  initial forever #10 sys_clk = ~sys_clk;
  initial begin
    repeat (100000) @(posedge sys_clk);
    errors++;
    final_report();
  end
  // phase counters and converter clock history
  always @(posedge sys_clk) begin
    capCycles <= capCycles + int'(sampleCapOpen);
    trackCycles <= trackCycles + int'(sampleTrack);
    validCount <= validCount + int'(resultValid);
    cvPrev <= converterClock;
  end

  task automatic final_report();
    $display("comparisons %0d, mismatches %0d", testsRun, errors);
    if (errors == 0 && testsRun > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // one single transfer; address held until hready, then data phase
  task automatic bus(input logic [5:0] idx, input logic w,
      input logic [31:0] wd, output logic [31:0] rd);
    int n;
    n = 0;
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, idx, 2'h0};
    do begin @(posedge sys_clk); n++; end while (!hreadyout && n < 50);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do begin @(posedge sys_clk); n++; end while (!hreadyout && n < 50);
    rd = hrdata;
    if (n >= 50) begin errors++; final_report(); end
  endtask
  task automatic wr(input logic [5:0] idx, input logic [31:0] d);
    logic [31:0] x;
    bus(idx, 1'b1, d, x);
  endtask
  task automatic rdchk(input logic [5:0] idx, input logic [31:0] e,
      input string nm);
    logic [31:0] x;
    bus(idx, 1'b0, 32'h0, x);
    `CHK(nm, e, x)
  endtask
  // poll the busy bit until the conversion is over
  task automatic waitIdle();
    logic [31:0] x;
    int n;
    n = 0;
    do begin bus(IDX_COMMAND, 1'b0, 32'h0, x); n++; end
      while (x[0] !== 1'b0 && n < 300);
    if (n >= 300) begin errors++; final_report(); end
  endtask
  task automatic convert();
    wr(IDX_COMMAND, 32'h1);
    waitIdle();
  endtask
  // cycles from the start command to the first sampling phase
  task automatic startCount(output int n);
    wr(IDX_COMMAND, 32'h1);
    n = 0;
    while (!sampleTrack && n < 1000) begin @(posedge sys_clk); n++; end
    waitIdle();
  endtask
  task automatic clkRise(output int n);
    n = 0;
    do begin @(posedge sys_clk); n++; end
      while (!(converterClock && !cvPrev) && n < 600);
  endtask
  task automatic irqChk(input logic e);
    repeat (2) @(posedge sys_clk);
    `CHK("irq", e, irq)
  endtask
  task automatic pulse(input logic wake);
    if (wake) deepSleepWake <= 1'b1;
    else eventTrigger <= 1'b1;
    @(posedge sys_clk);
    deepSleepWake <= 1'b0;
    eventTrigger <= 1'b0;
    @(posedge sys_clk);
  endtask

  // main sequence: table of window cases, then hand-written cases
  initial begin : main
    int n, c0, t0;
    repeat (10) @(posedge sys_clk);
    srst <= 1'b0;
    @(posedge sys_clk);
    wr(IDX_CONTROL, 32'h1);
    foreach (rows[i]) begin
      windowLowThreshold <= rows[i].lo;
      windowHighThreshold <= rows[i].hi;
      wr(IDX_CLOCK, {26'h0, rows[i].refc, 4'h0});
      wr(IDX_WINDOW, {29'h0, rows[i].mode});
      convert();
      `CHK("reference", rows[i].refc, referenceSelect)
      `CHK("output", 16'h0064, conversionOutput)
      `CHK("hresp", 1'b0, hresp)
      rdchk(IDX_STATUS, {30'h0, rows[i].hit, 1'b1}, "flags");
      rdchk(IDX_RESULT, 32'h64, "result");
      rdchk(IDX_STATUS, 32'h0, "cleared");
    end
    $display("window table done");
    srst <= 1'b1;
    repeat (10) @(posedge sys_clk);
    srst <= 1'b0;
    @(posedge sys_clk);
    foreach (regs[i]) rdchk(regs[i], 32'h0, "reset value");
    wr(IDX_DEBUG, 32'h1);
    rdchk(IDX_DEBUG, 32'h1, "debug");
    wr(6'h07, 32'hFF);
    rdchk(6'h07, 32'h0, "unmapped");
    $display("reset and map done");
    wr(IDX_CONTROL, 32'h1);
    wr(IDX_INTEN, 32'h3);
    windowLowThreshold <= 16'hFFFF;
    wr(IDX_WINDOW, {29'h0, WIN_BELOW});
    convert();
    irqChk(1'b1);
    wr(IDX_STATUS, 32'h0);
    rdchk(IDX_STATUS, 32'h3, "kept");
    wr(IDX_INTEN, 32'h0);
    irqChk(1'b0);
    wr(IDX_INTEN, 32'h2);
    irqChk(1'b1);
    wr(IDX_STATUS, 32'h2);
    irqChk(1'b0);
    wr(IDX_INTEN, 32'h1);
    irqChk(1'b1);
    wr(IDX_STATUS, 32'h1);
    irqChk(1'b0);
    $display("flags done");
    wr(IDX_ACCUM, 32'h1);
    wr(IDX_CLOCK, 32'h1);
    wr(IDX_TIMING, 32'h03);
    wr(IDX_SAMPLE_LENGTH_EXTENSION, 32'h1);
    c0 = capCycles;
    t0 = trackCycles;
    convert();
    `CHK("cap open", 3 * 4, capCycles - c0)
    `CHK("tracking", 2 * (2 + 1) * 4, trackCycles - t0)
    rdchk(IDX_RESULT, 32'hC8, "sum");
    wr(IDX_TIMING, 32'h1F);
    convert();
    rdchk(IDX_TIMING, 32'h11, "dither");
    $display("timing done");
    lat <= 8'h3C;
    wr(IDX_INPUT, 32'h1F);
    convert();
    `CHK("input", 5'h1F, inputSelect)
    wr(IDX_COMMAND, 32'h1);
    wr(IDX_INPUT, 32'h0B);
    `CHK("input held", 5'h1F, inputSelect)
    rdchk(IDX_COMMAND, 32'h1, "busy");
    waitIdle();
    `CHK("input new", 5'h0B, inputSelect)
    pulse(1'b0);
    rdchk(IDX_COMMAND, 32'h0, "event off");
    wr(IDX_EVENT, 32'h1);
    pulse(1'b0);
    rdchk(IDX_COMMAND, 32'h1, "event on");
    waitIdle();
    $display("input and event done");
    lat <= 8'h00;
    wr(IDX_ACCUM, 32'h0);
    wr(IDX_CLOCK, 32'h0);
    wr(IDX_TIMING, 32'h20);
    wr(IDX_CONTROL, 32'h0);
    wr(IDX_CONTROL, 32'h1);
    startCount(n);
    `CHK("enable wait", 1'b1, n >= 24)
    startCount(n);
    `CHK("no wait", 1'b1, n < 24)
    pulse(1'b1);
    startCount(n);
    `CHK("wake wait", 1'b1, n >= 24)
    wr(IDX_CONTROL, 32'h3);
    c0 = validCount;
    wr(IDX_COMMAND, 32'h1);
    repeat (100) @(posedge sys_clk);
    `CHK("restarts", 1'b1, validCount - c0 > 5)
    wr(IDX_CONTROL, 32'h1);
    waitIdle();
    $display("start-up and continuous done");
    for (int c = 0; c < 8; c++) begin
      wr(IDX_CLOCK, 32'(c));
      clkRise(n);
      clkRise(n);
      `CHK("divider", 2 << c, n)
    end
    $display("divider done");
    final_report();
  end
endmodule // adc_sequencer_control_bench

// ==== tb/adsq_front_model.sv ====
/*
  adsq_front_model: analogue front end behind the sequencer; answers
  each convert request with one resultValid pulse after lat cycles.
  Assumes convertRequest is held high until it is answered.
*/
`timescale 1ns/1ps
module adsq_front_model (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic convertRequest,
  input wire logic [9:0] level,
  input wire logic [7:0] lat,
  output logic resultValid,
  output logic [9:0] sampleResult
);
  logic [7:0] waitCnt;
  // count conversion time, then show the sample for one cycle only
  always @(posedge sys_clk) begin
    resultValid <= 1'b0;
    sampleResult <= ~sampleResult; // stale data never looks valid
    if (srst) begin
      sampleResult <= 10'h2AA;
      waitCnt <= 8'h00;
    end else if (!convertRequest || resultValid) begin
      waitCnt <= 8'h00;
    end else if (waitCnt >= lat) begin
      resultValid <= 1'b1;
      sampleResult <= level;
    end else begin
      waitCnt <= waitCnt + 8'h01;
    end
  end
endmodule // adsq_front_model

// ==== verilog/adsq_pkg.sv ====
/*
  adsq_pkg: register indices, field positions, reset values, codes and
  helper functions for the converter sequencer control block.
  Assumes a 32-bit AHB-Lite bus; each register takes one aligned word,
  byte address is four times the register index.
*/
package adsq_pkg;

  // register indices (byte address = index * 4)
  localparam logic [5:0] IDX_CONTROL = 6'h00;
  localparam logic [5:0] IDX_ACCUM = 6'h01;
  localparam logic [5:0] IDX_CLOCK = 6'h02;
  localparam logic [5:0] IDX_TIMING = 6'h03;
  localparam logic [5:0] IDX_WINDOW = 6'h04;
  localparam logic [5:0] IDX_SAMPLE_LENGTH_EXTENSION = 6'h05;
  localparam logic [5:0] IDX_INPUT = 6'h06;
  localparam logic [5:0] IDX_COMMAND = 6'h08;
  localparam logic [5:0] IDX_EVENT = 6'h09;
  localparam logic [5:0] IDX_INTEN = 6'h0A;
  localparam logic [5:0] IDX_STATUS = 6'h0B;
  localparam logic [5:0] IDX_DEBUG = 6'h0C;
  localparam logic [5:0] IDX_RESULT = 6'h10;

  // field positions
  localparam int POS_ENABLE = 0;
  localparam int POS_CONTINUOUS = 1;
  localparam int POS_REFERENCE_SELECT = 4;
  localparam int POS_STARTUP = 5;
  localparam int POS_DITHER = 4;
  localparam int POS_DONE = 0;
  localparam int POS_WMATCH = 1;

  // reset value shared by every control register
  localparam logic [7:0] RST_REG = 8'h00;

  // reference codes
  localparam logic [1:0] REF_INTERNAL = 2'h0;
  localparam logic [1:0] REF_SUPPLY = 2'h1;
  localparam logic [1:0] REF_EXTERNAL = 2'h2;

  // window comparator modes
  localparam logic [2:0] WIN_NONE = 3'h0;
  localparam logic [2:0] WIN_BELOW = 3'h1;
  localparam logic [2:0] WIN_ABOVE = 3'h2;
  localparam logic [2:0] WIN_INSIDE = 3'h3;
  localparam logic [2:0] WIN_OUTSIDE = 3'h4;

  // timing counts in converter clock cycles
  localparam logic [8:0] BASE_SAMPLE_CYCLES = 9'h002;
  localparam logic [8:0] STARTUP_UNIT = 9'h010;
  localparam logic [2:0] STARTUP_MAX_CODE = 3'h5;
  localparam logic [2:0] ACCUM_MAX_CODE = 3'h6;

  typedef enum {ST_IDLE, ST_STARTUP, ST_DELAY, ST_SAMPLE, ST_CONVERT}
    adsq_state_t;

  // start-up wait for a delay code; reserved codes give no wait
  function automatic logic [8:0] adsq_startup_cycles(input logic [2:0] c);
    if (c == 3'h0 || c > STARTUP_MAX_CODE) begin
      return 9'h000;
    end
    return STARTUP_UNIT << (c - 3'h1);
  endfunction

  // samples per conversion; reserved code falls back to one
  function automatic logic [6:0] adsq_sample_count(input logic [2:0] c);
    if (c > ACCUM_MAX_CODE) begin
      return 7'h01;
    end
    return 7'h01 << c;
  endfunction

  // window test of a finished result
  function automatic logic adsq_window_hit(input logic [2:0] mode,
      input logic [15:0] res, input logic [15:0] lo, input logic [15:0] hi);
    case (mode)
      WIN_BELOW: return res < lo;
      WIN_ABOVE: return res > hi;
      WIN_INSIDE: return (res > lo) && (res < hi);
      WIN_OUTSIDE: return (res < lo) || (res > hi);
      default: return 1'b0;
    endcase
  endfunction

endpackage

// ==== verilog/adsq_prescaler.sv ====
/*
  adsq_prescaler: makes the converter clock from the peripheral clock,
  dividing by 2 to the power (code + 1), and a one-cycle tick at each
  rising converter clock edge. Assumes code is stable while running.
*/
`timescale 1ns/1ps
module adsq_prescaler import adsq_pkg::*; #(
  parameter int CNT_W = 8
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic run,
  input wire logic [2:0] divCode,
  output logic convTick,
  output logic convClk
);

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic clk;
    logic tick;
  } adsq_clock_divider_code_t;

  adsq_clock_divider_code_t st_reg;
  adsq_clock_divider_code_t st_next;
  logic [CNT_W-1:0] halfLimit;

  // half period is 2^code peripheral cycles [RULE2]
  assign halfLimit = CNT_W'((CNT_W'(1) << divCode) - CNT_W'(1));

  // counter, converter clock level and tick
  always_comb begin
    st_next = st_reg;
    st_next.tick = 1'b0;
    if (!run) begin
      st_next.cnt = '0;
      st_next.clk = 1'b0;
    end else if (st_reg.cnt >= halfLimit) begin
      st_next.cnt = '0;
      st_next.clk = ~st_reg.clk;
      st_next.tick = ~st_reg.clk; // rising converter edge [RULE2]
    end else begin
      st_next.cnt = CNT_W'(st_reg.cnt + CNT_W'(1));
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign convTick = st_reg.tick;
  assign convClk = st_reg.clk;

endmodule // adsq_prescaler

// ==== verilog/adsq_sequencer.sv ====
/*
  adsq_sequencer: register file, conversion sequencer and window
  comparator of a single-ended converter. Assumes an AHB-Lite master,
  an analogue front end that answers each convert request with one
  resultValid pulse, and synchronous trigger and wake inputs.
*/
// Register access over AHB-Lite was decided locally.
//Contract
//RULE1: two-bit field picks internal, supply or external reference.
//RULE2: converter clock is peripheral clock divided by 2^(code+1).
//RULE3: wait 0..256 converter cycles before first sample after enable.
//RULE4: same start-up wait after waking from deep sleep.
//RULE5: insert exactly the inter-sample delay between samples, cap open.
//RULE6: dither adds one to delay field after each sample, wrapping.
//RULE7: sampling lasts two cycles plus the sample length extension.
//RULE8: window mode compares 16-bit result with low and high thresholds.
//RULE9: five-bit input select routes pins and internal sources.
//RULE10: input select change during conversion waits for its end.
//RULE11: writing one to start bit begins one measurement or series.
//RULE12: start bit reads one while converting, hardware clears it.
//RULE13: with event start enabled, an event starts a conversion.
//RULE14: enable bits 1 and 0 gate window and done interrupts.
//RULE15: window flag set only at conversion end on a match.
//RULE16: window flag clears on write one or result read.
//RULE17: done flag sets on new result, clears on write one or read.
//RULE18: continuous mode restarts immediately after each conversion.
//RULE19: accumulation count sums 1 to 64 samples per conversion.
//RULE20: interrupt asserted while an enabled flag is set.
`timescale 1ns/1ps
module adsq_sequencer import adsq_pkg::*; #(
  parameter int RES_W = 10
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic eventTrigger,
  input wire logic deepSleepWake,
  input wire logic [15:0] windowLowThreshold,
  input wire logic [15:0] windowHighThreshold,
  input wire logic resultValid,
  input wire logic [RES_W-1:0] sampleResult,
  output logic [1:0] referenceSelect,
  output logic [4:0] inputSelect,
  output logic converterClock,
  output logic sampleCapOpen,
  output logic sampleTrack,
  output logic convertRequest,
  output logic [15:0] conversionOutput,
  output logic irq
);

  typedef struct packed {
    adsq_state_t fsm;
    logic enable;
    logic continuousMode;
    logic [2:0] accumulationCount;
    logic [1:0] reference_select;
    logic [2:0] clockDividerCode;
    logic [7:0] timing;
    logic [2:0] windowMode;
    logic [4:0] sampleLen;
    logic [4:0] inputSel;
    logic eventStartEnable;
    logic [1:0] intEnable;
    logic [1:0] flags;
    logic debugRun;
    logic busy;
    logic startupPending;
    logic [16:0] cnt;
    logic [6:0] samplesLeft;
    logic [15:0] accum;
    logic [15:0] result;
    logic [4:0] activeInput;
    logic [1:0] activeRef;
    logic capOpen;
    logic track;
    logic convReq;
    logic irq;
    logic dpWrite;
    logic dpRead;
    logic [5:0] dpIndex;
    logic readyOut;
    logic [31:0] rdata;
  } adsq_regs_t;

  adsq_regs_t st_reg;
  adsq_regs_t st_next;
  logic convClk;
  logic addrPhase;
  logic wrStrobe;
  logic startReq;
  logic resultRead;
  logic sampleEnd;
  logic [1:0] flagSet;
  logic [1:0] flagClr;
  logic [15:0] finalSum;
  logic [31:0] readMux;
  logic [16:0] sampleLoad;

  // converter cycles to peripheral cycles at a divider code [RULE2]
  function automatic logic [16:0] toSys(input logic [8:0] n,
      input logic [2:0] d);
    return 17'(n) << (4'(d) + 4'h1);
  endfunction

  // sampling length in peripheral cycles, exact whatever the clock phase
  assign sampleLoad = toSys(9'(BASE_SAMPLE_CYCLES + 9'(st_reg.sampleLen)),
    st_reg.clockDividerCode); // [RULE7]

  // converter clock divider
  adsq_prescaler #(
    .CNT_W(8)
  ) u_prescaler (
    .sys_clk(sys_clk),
    .srst(srst),
    .run(st_reg.enable),
    .divCode(st_reg.clockDividerCode),
    .convTick(),
    .convClk(convClk)
  );

  // bus phase decode and side-effect strobes
  assign addrPhase = hsel && htrans[1] && hready;
  assign wrStrobe = st_reg.dpWrite;
  assign resultRead = st_reg.dpRead && st_reg.dpIndex == IDX_RESULT;
  assign startReq = st_reg.enable && !st_reg.busy &&
    ((wrStrobe && st_reg.dpIndex == IDX_COMMAND && hwdata[0]) || // [RULE11]
     (st_reg.eventStartEnable && eventTrigger)); // [RULE13]
  assign sampleEnd = st_reg.fsm == ST_CONVERT && resultValid;
  assign finalSum = 16'(st_reg.accum + 16'(sampleResult));

  // flag set at conversion end, clear by write one or result read
  always_comb begin
    flagSet = 2'b00;
    if (sampleEnd && st_reg.samplesLeft == 7'h01) begin
      flagSet[POS_DONE] = 1'b1; // [RULE17]
      flagSet[POS_WMATCH] = adsq_window_hit(st_reg.windowMode, finalSum,
        windowLowThreshold, windowHighThreshold); // [RULE8] [RULE15]
    end
    flagClr = {2{resultRead}}; // [RULE16] [RULE17]
    if (wrStrobe && st_reg.dpIndex == IDX_STATUS) begin
      flagClr = flagClr | hwdata[1:0]; // [RULE16]
    end
  end

  // register read data
  always_comb begin
    readMux = 32'h0000_0000;
    case (st_reg.dpIndex)
      IDX_CONTROL: readMux[1:0] = {st_reg.continuousMode, st_reg.enable};
      IDX_ACCUM: readMux[2:0] = st_reg.accumulationCount;
      IDX_CLOCK: readMux[7:0] = {2'b00, st_reg.reference_select, 1'b0,
        st_reg.clockDividerCode};
      IDX_TIMING: readMux[7:0] = st_reg.timing;
      IDX_WINDOW: readMux[2:0] = st_reg.windowMode;
      IDX_SAMPLE_LENGTH_EXTENSION: readMux[4:0] = st_reg.sampleLen;
      IDX_INPUT: readMux[4:0] = st_reg.inputSel;
      IDX_COMMAND: readMux[0] = st_reg.busy; // [RULE12]
      IDX_EVENT: readMux[0] = st_reg.eventStartEnable;
      IDX_INTEN: readMux[1:0] = st_reg.intEnable;
      IDX_STATUS: readMux[1:0] = st_reg.flags;
      IDX_DEBUG: readMux[0] = st_reg.debugRun;
      IDX_RESULT: readMux[15:0] = st_reg.result;
      default: readMux = 32'h0000_0000;
    endcase
  end

  // next state: bus slave, registers and conversion sequencer
  always_comb begin
    st_next = st_reg;
    // reads take one wait state so hrdata comes from a flop
    st_next.dpWrite = addrPhase && hwrite;
    st_next.dpRead = 1'b0;
    st_next.readyOut = 1'b1;
    if (addrPhase) begin
      st_next.dpIndex = haddr[7:2];
      st_next.readyOut = hwrite;
    end
    if (!st_reg.readyOut) begin
      st_next.rdata = readMux;
      st_next.dpRead = 1'b1;
    end
    // register writes in the data phase
    if (wrStrobe) begin
      case (st_reg.dpIndex)
        IDX_CONTROL: begin
          st_next.enable = hwdata[POS_ENABLE];
          st_next.continuousMode = hwdata[POS_CONTINUOUS];
          if (hwdata[POS_ENABLE] && !st_reg.enable) begin
            st_next.startupPending = 1'b1; // [RULE3]
          end
        end
        IDX_ACCUM: st_next.accumulationCount = hwdata[2:0]; // [RULE19]
        IDX_CLOCK: begin
          st_next.reference_select = hwdata[POS_REFERENCE_SELECT+:2]; // [RULE1]
          st_next.clockDividerCode = hwdata[2:0]; // [RULE2]
          if (hwdata[POS_REFERENCE_SELECT+:2] == REF_INTERNAL &&
              st_reg.reference_select != REF_INTERNAL) begin
            st_next.startupPending = 1'b1; // [RULE3]
          end
        end
        IDX_TIMING: st_next.timing = hwdata[7:0];
        IDX_WINDOW: st_next.windowMode = hwdata[2:0]; // [RULE8]
        IDX_SAMPLE_LENGTH_EXTENSION: st_next.sampleLen = hwdata[4:0]; // [RULE7]
        IDX_INPUT: st_next.inputSel = hwdata[4:0]; // [RULE9]
        IDX_EVENT: st_next.eventStartEnable = hwdata[0]; // [RULE13]
        IDX_INTEN: st_next.intEnable = hwdata[1:0]; // [RULE14]
        IDX_DEBUG: st_next.debugRun = hwdata[0];
        default: ;
      endcase
    end
    if (deepSleepWake) begin
      st_next.startupPending = 1'b1; // [RULE4]
    end
    // set wins over clear
    st_next.flags = (st_reg.flags & ~flagClr) | flagSet;
    st_next.capOpen = 1'b0;
    st_next.track = 1'b0;
    st_next.convReq = 1'b0;
    case (st_reg.fsm)
      ST_IDLE: begin
        if (startReq) begin
          st_next.busy = 1'b1; // [RULE12]
          st_next.activeInput = st_next.inputSel; // [RULE10]
          st_next.activeRef = st_next.reference_select;
          st_next.samplesLeft = adsq_sample_count(st_reg.accumulationCount);
          st_next.accum = 16'h0000;
          if (st_reg.startupPending) begin
            st_next.fsm = ST_STARTUP;
            st_next.cnt = toSys(adsq_startup_cycles(
              st_reg.timing[POS_STARTUP+:3]), st_reg.clockDividerCode);
          end else begin // [RULE3] [RULE4]
            st_next.fsm = ST_SAMPLE;
            st_next.track = 1'b1;
            st_next.cnt = sampleLoad;
          end
        end
      end
      ST_STARTUP: begin
        if (st_reg.cnt == 17'h00000) begin
          st_next.startupPending = 1'b0;
          st_next.fsm = ST_SAMPLE;
          st_next.track = 1'b1;
          st_next.cnt = sampleLoad;
        end else begin
          st_next.cnt = 17'(st_reg.cnt - 17'h00001);
        end
      end
      ST_DELAY: begin
        if (st_reg.cnt == 17'h00000) begin
          st_next.fsm = ST_SAMPLE;
          st_next.track = 1'b1;
          st_next.cnt = sampleLoad;
        end else begin
          st_next.capOpen = 1'b1; // cap open during the delay [RULE5]
          st_next.cnt = 17'(st_reg.cnt - 17'h00001);
        end
      end
      ST_SAMPLE: begin
        st_next.track = 1'b1;
        if (st_reg.cnt == 17'h00001) begin
          st_next.fsm = ST_CONVERT; // two plus extension cycles [RULE7]
          st_next.track = 1'b0;
          st_next.convReq = 1'b1;
        end else begin
          st_next.cnt = 17'(st_reg.cnt - 17'h00001);
        end
      end
      ST_CONVERT: begin
        st_next.convReq = 1'b1;
        if (resultValid) begin
          st_next.convReq = 1'b0;
          st_next.accum = finalSum; // [RULE19]
          if (st_reg.timing[POS_DITHER]) begin
            st_next.timing[3:0] = 4'(st_reg.timing[3:0] + 4'h1); // [RULE6]
          end
          if (st_reg.samplesLeft != 7'h01) begin
            st_next.samplesLeft = 7'(st_reg.samplesLeft - 7'h01);
            st_next.fsm = ST_DELAY;
            st_next.cnt = toSys(9'(st_reg.timing[3:0]),
              st_reg.clockDividerCode); // [RULE5]
          end else begin
            st_next.result = finalSum;
            st_next.activeInput = st_next.inputSel; // [RULE10]
            st_next.activeRef = st_next.reference_select;
            st_next.accum = 16'h0000;
            st_next.samplesLeft =
              adsq_sample_count(st_reg.accumulationCount);
            if (st_reg.continuousMode) begin
              st_next.fsm = ST_SAMPLE; // next conversion at once [RULE18]
              st_next.track = 1'b1;
              st_next.cnt = sampleLoad;
            end else begin
              st_next.fsm = ST_IDLE;
              st_next.busy = 1'b0; // [RULE12]
            end
          end
        end
      end
      default: st_next.fsm = ST_IDLE;
    endcase
    // disabling aborts any conversion
    if (!st_next.enable) begin
      st_next.fsm = ST_IDLE;
      st_next.busy = 1'b0;
      st_next.capOpen = 1'b0;
      st_next.track = 1'b0;
      st_next.convReq = 1'b0;
    end
    st_next.irq = |(st_next.flags & st_next.intEnable); // [RULE14] [RULE20]
  end

  // state register
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      st_reg <= '0;
      st_reg.fsm <= ST_IDLE;
      st_reg.readyOut <= 1'b1;
      st_reg.timing <= RST_REG;
    end else begin
      st_reg <= st_next;
    end
  end

  // outputs straight from flops, hresp tied low
  assign hreadyout = st_reg.readyOut;
  assign hresp = 1'b0;
  assign hrdata = st_reg.rdata;
  assign referenceSelect = st_reg.activeRef; // [RULE1]
  assign inputSelect = st_reg.activeInput; // [RULE9]
  assign converterClock = convClk;
  assign sampleCapOpen = st_reg.capOpen;
  assign sampleTrack = st_reg.track;
  assign convertRequest = st_reg.convReq;
  assign conversionOutput = st_reg.result;
  assign irq = st_reg.irq;

  // assertions
  a_sample_min_len: assert property (@(posedge sys_clk) disable iff (srst) // [RULE7]
    $rose(sampleTrack) |-> sampleTrack [*4])
    else $error("sampling shorter than two converter cycles");

  a_done_flag_set: assert property (@(posedge sys_clk) disable iff (srst) // [RULE17]
    (sampleEnd && st_reg.samplesLeft == 7'h01 && st_reg.enable)
      |=> st_reg.flags[POS_DONE])
    else $error("done flag not set at conversion end");

  a_busy_reads_one: assert property (@(posedge sys_clk) disable iff (srst) // [RULE12]
    (st_reg.fsm != ST_IDLE) == st_reg.busy)
    else $error("start bit does not track conversion");

  a_input_held: assert property (@(posedge sys_clk) disable iff (srst) // [RULE10]
    (convertRequest && $past(convertRequest)) |-> $stable(inputSelect))
    else $error("input selection changed mid conversion");

  a_irq_gate: assert property (@(posedge sys_clk) disable iff (srst) // [RULE20]
    irq |-> $past(|(st_next.flags & st_next.intEnable)))
    else $error("interrupt without enabled flag");

  a_wmatch_at_end: assert property (@(posedge sys_clk) disable iff (srst) // [RULE15]
    $rose(st_reg.flags[POS_WMATCH]) |-> $past(sampleEnd))
    else $error("window flag set outside conversion end");

  a_dither_wrap: assert property (@(posedge sys_clk) disable iff (srst) // [RULE6]
    (sampleEnd && st_reg.timing[POS_DITHER] && st_reg.timing[3:0] == 4'hF)
      |=> st_reg.timing[3:0] == 4'h0)
    else $error("delay dither did not wrap");

  a_event_start: assert property (@(posedge sys_clk) disable iff (srst) // [RULE13]
    (st_reg.fsm == ST_IDLE && st_reg.enable && st_reg.eventStartEnable &&
     eventTrigger && !(wrStrobe && st_reg.dpIndex == IDX_CONTROL))
      |=> st_reg.fsm != ST_IDLE)
    else $error("event did not start a conversion");

  a_flag_w1c: assert property (@(posedge sys_clk) disable iff (srst) // [RULE16]
    (wrStrobe && st_reg.dpIndex == IDX_STATUS && hwdata[POS_WMATCH] &&
     !flagSet[POS_WMATCH]) |=> !st_reg.flags[POS_WMATCH])
    else $error("window flag not cleared by write one");

endmodule // adsq_sequencer
